// >>> rtl/sub_datapath_defs.svh
// Offsets, field positions, opcodes and reset values of the subtract datapath
`ifndef SUB_DATAPATH_DEFS_SVH
`define SUB_DATAPATH_DEFS_SVH

// Register byte offsets on the APB
`define OFS_INSTR 8'h00
`define OFS_WORK 8'h04
`define OFS_STATUS 8'h08
`define OFS_FADDR 8'h0C
`define OFS_FDATA 8'h10

// Status register bit positions
`define ST_CARRY 0
`define ST_DCARRY 1
`define ST_ZERO 2
`define ST_OVF 3
`define ST_ILLEGAL 4
`define ST_BUSY 5

// Instruction word fields
`define OPC_LIT 8'hB2
`define OPC_REG_SUB 7'h02
`define OPC_REG_SUBB 7'h01
`define INSTR_HI 15
`define INSTR_DEST 8
`define INSTR_OPC8_LO 8
`define INSTR_OPC7_LO 9

// Reset values
`define RST_BYTE 8'h00
`define RST_INSTR 16'h0000
`define RST_WORD 32'h0000_0000

`endif

// >>> rtl/sub_datapath_pkg.sv
// Types shared by the subtract datapath modules
`default_nettype none
package sub_datapath_pkg;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_LIT = 2'b01,
    OP_REG = 2'b10,
    OP_REG_BORROW = 2'b11
  } sub_op_e;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1 = 3'b001,
    PH_Q2 = 3'b010,
    PH_Q3 = 3'b011,
    PH_Q4 = 3'b100
  } phase_e;

  typedef struct packed {
    logic ovf;
    logic zero;
    logic dcarry;
    logic carry;
  } status_flags_s;

  typedef struct packed {
    sub_op_e op;
    logic to_file;
    logic [7:0] operand;
  } decoded_s;

endpackage
`default_nettype wire

// >>> rtl/borrow_subtractor.sv
// Eight-bit subtractor with carry-as-inverted-borrow and status flags
`default_nettype none
module borrow_subtractor (
  input wire logic [7:0] i_minuend,
  input wire logic [7:0] i_subtrahend,
  input wire logic i_carry_in,
  output logic [7:0] o_diff,
  output sub_datapath_pkg::status_flags_s o_flags
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Two's complement: a + ~b + carry, carry high means no borrow
  always_comb
  begin
    full_sum = {1'b0, i_minuend} + {1'b0, ~i_subtrahend}
             + {8'h00, i_carry_in};
    low_sum = {1'b0, i_minuend[3:0]} + {1'b0, ~i_subtrahend[3:0]}
            + {4'h0, i_carry_in};
    o_diff = full_sum[7:0];
    o_flags.carry = full_sum[8];
    o_flags.zero = (full_sum[7:0] == 8'h00);
    o_flags.dcarry = low_sum[4];
    o_flags.ovf = (i_minuend[7] != i_subtrahend[7])
               && (full_sum[7] != i_minuend[7]);
  end

endmodule
`default_nettype wire

// >>> rtl/sub_datapath.sv
// Subtract instruction datapath with working register, file and APB slave
//
// How it works
// - File minus working; destination bit 0 to working, 1 to file.
// - Borrow form also subtracts the inverted carry from the file value.
// - Borrow form: destination bit 0 to working, 1 back to file.
// - Positive nonzero result sets carry and clears zero.
// - Zero result sets carry and sets zero.
// - Negative result stores two's complement byte and clears carry.
// - Literal form subtracts working register from literal into working.
// - Literal form updates overflow, carry, digit carry and zero flags.
`include "sub_datapath_defs.svh"
`default_nettype none
module sub_datapath #(
  parameter int FILE_DEPTH = 256
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_busy
);

  localparam int IDX_W = $clog2(FILE_DEPTH);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire logic rst_n;
  assign rst_n = rst_sync_ff;

  // ------------------------------------------------------------
  // State declarations
  // ------------------------------------------------------------
  sub_datapath_pkg::phase_e phase_ff, nxt_phase;
  sub_datapath_pkg::decoded_s dec_ff, nxt_dec;
  sub_datapath_pkg::status_flags_s flags_ff, nxt_flags;
  sub_datapath_pkg::status_flags_s res_flags_ff, nxt_res_flags;
  logic [15:0] instr_ff, nxt_instr;
  logic [7:0] work_ff, nxt_work;
  logic [7:0] opnd_ff, nxt_opnd;
  logic [7:0] result_ff, nxt_result;
  logic [7:0] faddr_ff, nxt_faddr;
  logic illegal_ff, nxt_illegal;
  logic [7:0] file_ff [FILE_DEPTH];
  logic [7:0] nxt_file [FILE_DEPTH];
  logic ack_ff, nxt_ack;
  logic slverr_ff, nxt_slverr;
  logic [31:0] prdata_ff, nxt_prdata;

  logic [7:0] alu_diff;
  sub_datapath_pkg::status_flags_s alu_flags;
  logic alu_carry_in;
  logic [7:0] alu_minuend;

  logic idle;
  logic bus_wr;
  logic addr_ok;
  logic [IDX_W-1:0] dec_idx;
  logic [IDX_W-1:0] sw_idx;

  assign idle = (phase_ff == sub_datapath_pkg::PH_IDLE);
  assign dec_idx = dec_ff.operand[IDX_W-1:0];
  assign sw_idx = faddr_ff[IDX_W-1:0];

  // ------------------------------------------------------------
  // Arithmetic unit
  // ------------------------------------------------------------
  // Q2 latches the minuend, the working register is the subtrahend
  assign alu_minuend = opnd_ff;
  assign alu_carry_in = (dec_ff.op == sub_datapath_pkg::OP_REG_BORROW) ?
                        flags_ff.carry : 1'b1;

  borrow_subtractor u_sub (
    .i_minuend(alu_minuend),
    .i_subtrahend(work_ff),
    .i_carry_in(alu_carry_in),
    .o_diff(alu_diff),
    .o_flags(alu_flags)
  );

  // ------------------------------------------------------------
  // Status read word
  // ------------------------------------------------------------
  logic [31:0] status_word;

  always_comb
  begin
    status_word = `RST_WORD;
    status_word[`ST_CARRY] = flags_ff.carry;
    status_word[`ST_DCARRY] = flags_ff.dcarry;
    status_word[`ST_ZERO] = flags_ff.zero;
    status_word[`ST_OVF] = flags_ff.ovf;
    status_word[`ST_ILLEGAL] = illegal_ff;
    status_word[`ST_BUSY] = !idle;
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // One wait state, and no answer at all while an instruction runs
  always_comb
  begin
    addr_ok = (i_paddr == `OFS_INSTR) || (i_paddr == `OFS_WORK)
           || (i_paddr == `OFS_STATUS) || (i_paddr == `OFS_FADDR)
           || (i_paddr == `OFS_FDATA);
    nxt_ack = i_psel && i_penable && !ack_ff && idle;
    nxt_slverr = nxt_ack && !addr_ok;
    nxt_prdata = prdata_ff;
    if (nxt_ack && !i_pwrite)
    begin
      nxt_prdata = `RST_WORD;
      unique case (i_paddr)
        `OFS_INSTR: nxt_prdata[15:0] = instr_ff;
        `OFS_WORK: nxt_prdata[7:0] = work_ff;
        `OFS_STATUS: nxt_prdata = status_word;
        `OFS_FADDR: nxt_prdata[7:0] = faddr_ff;
        `OFS_FDATA: nxt_prdata[7:0] = file_ff[sw_idx];
        default: nxt_prdata = `RST_WORD;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      slverr_ff <= 1'b0;
      prdata_ff <= `RST_WORD;
    end
    else
    begin
      ack_ff <= nxt_ack;
      slverr_ff <= nxt_slverr;
      prdata_ff <= nxt_prdata;
    end
  end

  assign bus_wr = i_psel && i_penable && ack_ff && i_pwrite;
  assign o_pready = ack_ff;
  assign o_pslverr = slverr_ff;
  assign o_prdata = prdata_ff;
  assign o_busy = !idle;

  // ------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------
  sub_datapath_pkg::decoded_s dec_word;

  always_comb
  begin
    dec_word.to_file = instr_ff[`INSTR_DEST];
    dec_word.operand = instr_ff[7:0];
    if (instr_ff[`INSTR_HI:`INSTR_OPC8_LO] == `OPC_LIT)
    begin
      dec_word.op = sub_datapath_pkg::OP_LIT;
      dec_word.to_file = 1'b0;
    end
    else if (instr_ff[`INSTR_HI:`INSTR_OPC7_LO] == `OPC_REG_SUB)
      dec_word.op = sub_datapath_pkg::OP_REG;
    else if (instr_ff[`INSTR_HI:`INSTR_OPC7_LO] == `OPC_REG_SUBB)
      dec_word.op = sub_datapath_pkg::OP_REG_BORROW;
    else
      dec_word.op = sub_datapath_pkg::OP_NONE;
  end

  // ------------------------------------------------------------
  // Quarter phase sequencer and datapath
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_phase = phase_ff;
    nxt_instr = instr_ff;
    nxt_dec = dec_ff;
    nxt_opnd = opnd_ff;
    nxt_result = result_ff;
    nxt_res_flags = res_flags_ff;
    nxt_work = work_ff;
    nxt_flags = flags_ff;
    nxt_illegal = illegal_ff;
    nxt_faddr = faddr_ff;
    nxt_file = file_ff;
    unique case (phase_ff)
      sub_datapath_pkg::PH_IDLE:
      begin
        if (bus_wr)
        begin
          unique case (i_paddr)
            `OFS_INSTR:
            begin
              nxt_instr = i_pwdata[15:0];
              nxt_phase = sub_datapath_pkg::PH_Q1;
            end
            `OFS_WORK: nxt_work = i_pwdata[7:0];
            `OFS_STATUS:
            begin
              nxt_flags.carry = i_pwdata[`ST_CARRY];
              nxt_flags.dcarry = i_pwdata[`ST_DCARRY];
              nxt_flags.zero = i_pwdata[`ST_ZERO];
              nxt_flags.ovf = i_pwdata[`ST_OVF];
              if (i_pwdata[`ST_ILLEGAL])
                nxt_illegal = 1'b0;
            end
            `OFS_FADDR: nxt_faddr = i_pwdata[7:0];
            `OFS_FDATA: nxt_file[sw_idx] = i_pwdata[7:0];
            default: nxt_phase = sub_datapath_pkg::PH_IDLE;
          endcase
        end
      end
      sub_datapath_pkg::PH_Q1:
      begin
        nxt_dec = dec_word;
        nxt_phase = sub_datapath_pkg::PH_Q2;
      end
      sub_datapath_pkg::PH_Q2:
      begin
        // Operand read: literal or file register
        if (dec_ff.op == sub_datapath_pkg::OP_LIT)
          nxt_opnd = dec_ff.operand;
        else
          nxt_opnd = file_ff[dec_idx];
        nxt_phase = sub_datapath_pkg::PH_Q3;
      end
      sub_datapath_pkg::PH_Q3:
      begin
        nxt_result = alu_diff;
        nxt_res_flags = alu_flags;
        nxt_phase = sub_datapath_pkg::PH_Q4;
      end
      sub_datapath_pkg::PH_Q4:
      begin
        // Destination write and flag update
        if (dec_ff.op == sub_datapath_pkg::OP_NONE)
          nxt_illegal = 1'b1;
        else
        begin
          nxt_flags = res_flags_ff;
          if (dec_ff.to_file)
            nxt_file[dec_idx] = result_ff;
          else
            nxt_work = result_ff;
        end
        nxt_phase = sub_datapath_pkg::PH_IDLE;
      end
      default: nxt_phase = sub_datapath_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_ff <= sub_datapath_pkg::PH_IDLE;
      instr_ff <= `RST_INSTR;
      dec_ff <= '0;
      opnd_ff <= `RST_BYTE;
      result_ff <= `RST_BYTE;
      res_flags_ff <= '0;
      work_ff <= `RST_BYTE;
      flags_ff <= '0;
      illegal_ff <= 1'b0;
      faddr_ff <= `RST_BYTE;
      for (int i = 0; i < FILE_DEPTH; i++)
        file_ff[i] <= `RST_BYTE;
    end
    else
    begin
      phase_ff <= nxt_phase;
      instr_ff <= nxt_instr;
      dec_ff <= nxt_dec;
      opnd_ff <= nxt_opnd;
      result_ff <= nxt_result;
      res_flags_ff <= nxt_res_flags;
      work_ff <= nxt_work;
      flags_ff <= nxt_flags;
      illegal_ff <= nxt_illegal;
      faddr_ff <= nxt_faddr;
      file_ff <= nxt_file;
    end
  end

endmodule
`default_nettype wire

// >>> bench/sub_datapath_sva.sv
// Port timing checker for the subtract datapath
`default_nettype none
module sub_datapath_chk (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  property p_busy_len;
    $rose(o_busy) |-> o_busy [*4] ##1 !o_busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  property p_start;
    o_pready && i_pwrite && i_paddr == 8'h00 |=> o_busy;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_busy_quiet;
    o_busy |-> !o_pready;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("ack busy");
  property p_pulse;
    o_pready |=> !o_pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready width");
  property p_err_ack;
    o_pslverr |-> o_pready && i_psel && i_penable;
  endproperty
  a_err_ack: assert property (p_err_ack) else $error("lone error");
  property p_unmapped;
    o_pready && i_paddr > 8'h10 |-> o_pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_mapped;
    o_pready && i_paddr <= 8'h10 && i_paddr[1:0] == 2'b00 |-> !o_pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("false error");
  property p_wait;
    $rose(i_penable) && i_psel && !o_busy |-> !o_pready ##1 o_pready;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state");
endmodule
bind sub_datapath sub_datapath_chk chk (
  .i_mclk(i_mclk),
  .i_reset_n(i_reset_n),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_pwrite(i_pwrite),
  .i_paddr(i_paddr),
  .i_pwdata(i_pwdata),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_busy(o_busy)
);
`default_nettype wire

// >>> bench/sub_ref_model.sv
// Behavioural subtract core giving expected results and flags
`default_nettype none
module sub_ref_model (
  input wire logic [7:0] i_minuend,
  input wire logic [7:0] i_subtrahend,
  input wire logic i_carry_in,
  output logic [7:0] o_diff,
  output sub_datapath_pkg::status_flags_s o_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  int borrow;
  int diff;
  int sdiff;
  // Plain integer arithmetic: borrow is the inverted carry
  always_comb
  begin
    borrow = i_carry_in ? 0 : 1;
    diff = int'(i_minuend) - int'(i_subtrahend) - borrow;
    sdiff = int'($signed(i_minuend)) - int'($signed(i_subtrahend))
          - borrow;
    o_diff = diff[7:0];
    o_flags.carry = (diff >= 0);
    o_flags.zero = (diff[7:0] == 8'h00);
    o_flags.dcarry = (int'(i_minuend[3:0])
                      >= int'(i_subtrahend[3:0]) + borrow);
    o_flags.ovf = (sdiff < -128) || (sdiff > 127);
  end
endmodule
`default_nettype wire

// >>> bench/sub_datapath_tb.sv
// Self-checking bench for the subtract datapath
`default_nettype none
module sub_datapath_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic o_busy;
  logic [7:0] rm = 8'h00;
  logic [7:0] rs = 8'h00;
  logic rc = 1'b1;
  logic [7:0] rd;
  sub_datapath_pkg::status_flags_s rf;
  logic [31:0] q;
  logic e;
  int n_fail = 0;
  int n_checks = 0;
  always #5 i_mclk = ~i_mclk;
  sub_datapath #(.FILE_DEPTH(256)) dut (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_busy(o_busy)
  );
  sub_ref_model gold (
    .i_minuend(rm),
    .i_subtrahend(rs),
    .i_carry_in(rc),
    .o_diff(rd),
    .o_flags(rf)
  );
  task automatic results();
  begin
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
  begin
    n_checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
  begin
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    @(posedge i_mclk);
    while (o_pready !== 1'b1)
      @(posedge i_mclk);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  end
  endtask
  // Loads operands, runs one instruction, reads back both targets
  task automatic run(input logic [15:0] ins, input logic [7:0] w,
                     input logic [7:0] f, input logic c);
    logic lit;
    logic to_f;
  begin
    lit = ins[15:8] == 8'hB2;
    to_f = !lit && ins[8];
    rm = lit ? ins[7:0] : f;
    rs = w;
    rc = ins[15:9] == 7'h01 ? c : 1'b1;
    apb(1'b1, 8'h04, {24'h00_0000, w});
    apb(1'b1, 8'h08, {31'h0000_0000, c});
    apb(1'b1, 8'h0C, {24'h00_0000, ins[7:0]});
    apb(1'b1, 8'h10, {24'h00_0000, f});
    apb(1'b1, 8'h00, {16'h0000, ins});
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("file", {24'h00_0000, to_f ? rd : f}, q);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("work", {24'h00_0000, to_f ? w : rd}, q);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("status", {28'h000_0000, rf}, q);
  end
  endtask
  initial
  begin
    repeat (20) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    run(16'hB202, 8'h01, 8'h55, 1'b0);
    run(16'hB202, 8'h02, 8'h55, 1'b0);
    run(16'hB202, 8'h03, 8'h55, 1'b1);
    run(16'hB280, 8'h01, 8'h55, 1'b0);
    run(16'h0505, 8'h02, 8'h03, 1'b0);
    run(16'h0405, 8'h02, 8'h03, 1'b0);
    run(16'h0307, 8'h0D, 8'h19, 1'b1);
    run(16'h0207, 8'h1A, 8'h1B, 1'b0);
    run(16'h0309, 8'h0E, 8'h03, 1'b1);
    // Unknown opcode: flags and working register kept, sticky bit set
    apb(1'b1, 8'h08, 32'h0000_0005);
    apb(1'b1, 8'h00, 32'h0000_1234);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("illegal", 32'h0000_0015, q);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("work kept", 32'h0000_000E, q);
    apb(1'b1, 8'h08, 32'h0000_0010);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("illegal clear", 32'h0000_0000, q);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, e});
    chk("rdata", 32'h0000_0000, q);
    results();
  end
  initial
  begin
    repeat (5000) @(posedge i_mclk);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
